// ===== inc/timer_pkg.sv
/*
 * Shared constants and types for the prescaled down-counting timer.
 * Assumes an 8-bit register port and one clock at 250 MHz.
 */
package timer_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register port layout
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 8;
    localparam int PRESC_W = 7;
    localparam int SEL_W = 3;
    localparam logic [ADDR_W-1:0] COUNTER_OFFSET = 2'h0;
    localparam logic [ADDR_W-1:0] CONTROL_OFFSET = 2'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of timer_control
    localparam int REQ_FLAG_BIT = 7;
    localparam int IRQ_MASK_BIT = 6;
    localparam int EXT_SEL_BIT = 5;
    localparam int PIN_EN_BIT = 4;
    localparam int PRESC_CLR_BIT = 3;
    localparam int SEL_LO_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values and vectors
    localparam logic [COUNT_W-1:0] COUNTER_PRESET = 8'hf0;
    localparam logic [SEL_W-1:0] SEL_POWER_ON = 3'h0;
    localparam logic [15:0] VECTOR_NORMAL = 16'h1ff8;
    localparam logic [15:0] VECTOR_WAIT = 16'h1ff6;
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;

    // Stored control fields; the prescaler clear bit is never stored
    typedef struct packed {
        logic             req_flag;
        logic             irq_mask;
        logic             ext_clock_select;
        logic             ext_pin_enable;
        logic [SEL_W-1:0] prescale_select;
    } ctrl_type;

    // Count source modes, from {ext_clock_select, ext_pin_enable}
    typedef enum logic [1:0] {
        SRC_INTERNAL,
        SRC_GATED,
        SRC_OFF,
        SRC_PIN
    } src_mode_type;

endpackage

// ===== hw/timer_prescaler.sv
/*
 * Hidden ripple prescaler with a tap select.
 * Assumes tick_i is a one-cycle pulse marking a falling source edge.
 */
`timescale 1ns/1ps

module timer_prescaler #(
    parameter int PRESC_W = timer_pkg::PRESC_W,
    parameter int SEL_W   = timer_pkg::SEL_W
) (
    input  wire logic             clk_i,
    input  wire logic             clear_i,
    input  wire logic             tick_i,
    input  wire logic [SEL_W-1:0] select_i,
    output logic                  out_tick_o
);

    logic [PRESC_W-1:0] presc_q;
    logic [PRESC_W-1:0] presc_d;
    logic [PRESC_W-1:0] low_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Tap decode: select n fires when the low n bits roll over, giving 2**n
    // ratio by select
    assign low_mask = ~(({PRESC_W{1'b1}}) << select_i);
    assign out_tick_o = tick_i && ((presc_q & low_mask) == low_mask);

    // Clear wins over a tick so counting restarts truncation-free
    // clear to zero
    assign presc_d = clear_i ? '0 : (tick_i ? presc_q + 1'b1 : presc_q);

    always_ff @(posedge clk_i)
    begin
        presc_q <= presc_d;
    end

endmodule

// ===== hw/prescaled_down_timer.sv
/*
 * Prescaled 8-bit down timer with control register and request flag.
 * Assumes a core-side byte register port, a sampled instruction-cycle
 * clock level, a sampled timer pin, and core status levels for the
 * processor interrupt mask, wait and stop.
 */
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps

module prescaled_down_timer (
    input  wire logic                         clk_i,
    input  wire logic                         reset_i,
    input  wire logic                         ext_reset_i,
    input  wire logic [timer_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [timer_pkg::DATA_W-1:0] wdata_i,
    input  wire logic                         write_i,
    input  wire logic                         read_i,
    output logic      [timer_pkg::DATA_W-1:0] rdata_o,
    input  wire logic                         cycle_clk_i,
    input  wire logic                         timer_pin_i,
    input  wire logic                         cpu_imask_i,
    input  wire logic                         wait_i,
    input  wire logic                         stop_i,
    input  wire logic                         ext_irq_pending_i,
    output logic                              timer_irq_o,
    output logic      [15:0]                  vector_o,
    output logic                              imask_clear_o,
    output logic                              core_clk_en_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    timer_pkg::ctrl_type                 ctrl_q;
    timer_pkg::ctrl_type                 ctrl_d;
    timer_pkg::src_mode_type             src_mode;
    logic [timer_pkg::COUNT_W-1:0]       count_q;
    logic [timer_pkg::COUNT_W-1:0]       count_d;
    logic [timer_pkg::DATA_W-1:0]        rdata_q;
    logic [timer_pkg::DATA_W-1:0]        rdata_d;
    logic [timer_pkg::DATA_W-1:0]        ctrl_view;
    logic [15:0]                         vector_q;
    logic [15:0]                         vector_d;
    logic                                src_prev_q;
    logic                                wait_prev_q;
    logic                                src_level;
    logic                                src_fall;
    logic                                count_tick;
    logic                                hit_zero;
    logic                                wr_count;
    logic                                wr_ctrl;
    logic                                rd_count;
    logic                                rd_ctrl;
    logic                                presc_clear;
    logic                                any_reset;

    ////////////////////////////////////////////////////////////////////////////
    // Register port decode

    // Each strobe is qualified by its own offset
    assign wr_count = write_i && (addr_i == timer_pkg::COUNTER_OFFSET);
    assign wr_ctrl  = write_i && (addr_i == timer_pkg::CONTROL_OFFSET);
    assign rd_count = read_i && (addr_i == timer_pkg::COUNTER_OFFSET);
    assign rd_ctrl  = read_i && (addr_i == timer_pkg::CONTROL_OFFSET);

    // Either reset source acts on the flag and mask bits
    assign any_reset = reset_i || ext_reset_i;

    ////////////////////////////////////////////////////////////////////////////
    // Count source selection

    // Mode comes straight from the two source bits
    assign src_mode = timer_pkg::src_mode_type'({ctrl_q.ext_clock_select,
                                                 ctrl_q.ext_pin_enable});

    // Level of the selected source; the falling edge of it is the tick
    always_comb
    begin
        case (src_mode)
            timer_pkg::SRC_INTERNAL: src_level = cycle_clk_i;
            timer_pkg::SRC_GATED:    src_level = cycle_clk_i & timer_pin_i;
            timer_pkg::SRC_OFF:      src_level = 1'b0;
            timer_pkg::SRC_PIN:      src_level = timer_pin_i;
            default:                 src_level = 1'b0;
        endcase
    end

    // Previous level of the source, for edge detection
    always_ff @(posedge clk_i)
    begin
        src_prev_q <= src_level;
    end

    // Switching modes while the old source is high may give one extra edge;
    // software is expected to clear the prescaler after a mode change.
    // falling edge only
    assign src_fall = src_prev_q && !src_level;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler

    assign presc_clear = reset_i || stop_i ||
                         (wr_ctrl && wdata_i[timer_pkg::PRESC_CLR_BIT]);

    timer_prescaler #(
        .PRESC_W (timer_pkg::PRESC_W),
        .SEL_W   (timer_pkg::SEL_W)
    ) u_prescaler (
        .clk_i      (clk_i),
        .clear_i    (presc_clear),
        .tick_i     (src_fall && !stop_i),
        .select_i   (ctrl_q.prescale_select),
        .out_tick_o (count_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    // Zero is reached only by a decrement from one, not by a load
    // decrement into zero
    assign hit_zero = count_tick && !stop_i && !wr_count &&
                      (count_q == {{(timer_pkg::COUNT_W-1){1'b0}}, 1'b1});

    // Next counter value, highest priority first
    always_comb
    begin
        count_d = count_q;
        if (reset_i || stop_i)
        begin
            count_d = timer_pkg::COUNTER_PRESET;
        end
        else if (wr_count)
        begin
            count_d = wdata_i[timer_pkg::COUNT_W-1:0];
        end
        else if (count_tick)
        begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        count_q <= count_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    // Flag and mask follow the resets; source and select keep their value
    // across an external reset, and only power-on gives them a first value
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wr_ctrl)
        begin
            ctrl_d.req_flag         = wdata_i[timer_pkg::REQ_FLAG_BIT];
            ctrl_d.irq_mask         = wdata_i[timer_pkg::IRQ_MASK_BIT];
            ctrl_d.ext_clock_select = wdata_i[timer_pkg::EXT_SEL_BIT];
            ctrl_d.ext_pin_enable   = wdata_i[timer_pkg::PIN_EN_BIT];
            ctrl_d.prescale_select  =
                wdata_i[timer_pkg::SEL_LO_BIT +: timer_pkg::SEL_W];
        end
        if (hit_zero)
        begin
            ctrl_d.req_flag = 1'b1;   // Set wins over a same-cycle clear by a write; a reset clear still wins over the set
        end
        if (any_reset || stop_i)
        begin
            ctrl_d.req_flag = 1'b0;
        end
        if (any_reset || stop_i)
        begin
            ctrl_d.irq_mask = 1'b1;
        end
        if (reset_i)
        begin
            ctrl_d.ext_clock_select = 1'b0;
            ctrl_d.ext_pin_enable   = 1'b0;
            ctrl_d.prescale_select  = timer_pkg::SEL_POWER_ON;
        end
    end

    always_ff @(posedge clk_i)
    begin
        ctrl_q <= ctrl_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    assign ctrl_view = {ctrl_q.req_flag,
                        ctrl_q.irq_mask,
                        ctrl_q.ext_clock_select,
                        ctrl_q.ext_pin_enable,
                        1'b0,
                        ctrl_q.prescale_select};

    // Snapshot taken at the strobe edge, so a decrement in the data cycle
    // cannot tear the value; the counter itself is never touched by a read
    // stable, undisturbing read
    assign rdata_d = rd_count ? count_q :
                     rd_ctrl  ? ctrl_view :
                                timer_pkg::UNMAPPED_READ;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            rdata_q <= timer_pkg::UNMAPPED_READ;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request and vector

    // Mask set leaves the flag visible for polling but raises nothing
    // flag and masks clear
    assign timer_irq_o = ctrl_q.req_flag && !ctrl_q.irq_mask && !cpu_imask_i;

    // An external request in wait is taken first, which ends the wait, so a
    // timer request left over is then served through the normal vector
    // external first in wait
    assign vector_d = (wait_i && !ext_irq_pending_i) ? timer_pkg::VECTOR_WAIT
                                                     : timer_pkg::VECTOR_NORMAL;

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            vector_q <= timer_pkg::VECTOR_NORMAL;
        end
        else
        begin
            vector_q <= vector_d;
        end
    end

    assign vector_o = vector_q;

    ////////////////////////////////////////////////////////////////////////////
    // Low-power states

    // Wait entry is detected once, to clear the processor mask one time
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wait_prev_q <= 1'b0;
        end
        else
        begin
            wait_prev_q <= wait_i;
        end
    end

    // The timer itself is never gated in wait; only the core clock is
    // wait gates core, clears mask
    assign imask_clear_o = wait_i && !wait_prev_q;
    assign core_clk_en_o = !wait_i && !stop_i;

endmodule

// ===== verification/prescaled_down_timer_monitor.sv
/*
 * Port checker for the prescaled down timer.
 * Assumes it is bound to every timer instance and sees only its ports.
 */
`timescale 1ns/1ps

module prescaled_down_timer_monitor (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        ext_reset_i,
    input wire logic [1:0]  addr_i,
    input wire logic [7:0]  wdata_i,
    input wire logic        write_i,
    input wire logic        read_i,
    input wire logic [7:0]  rdata_o,
    input wire logic        cycle_clk_i,
    input wire logic        timer_pin_i,
    input wire logic        cpu_imask_i,
    input wire logic        wait_i,
    input wire logic        stop_i,
    input wire logic        ext_irq_pending_i,
    input wire logic        timer_irq_o,
    input wire logic [15:0] vector_o,
    input wire logic        imask_clear_o,
    input wire logic        core_clk_en_o
);
    default clocking mon_cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt gating and vectors
    chk_irq_cpu_mask: assert property (cpu_imask_i |-> !timer_irq_o)
        else $error("timer irq while cpu masked");
    chk_vector_wait: assert property ((wait_i && !ext_irq_pending_i) |=>
        vector_o == timer_pkg::VECTOR_WAIT) else $error("wait vector missing");
    chk_vector_normal: assert property (!(wait_i && !ext_irq_pending_i) |=>
        vector_o == timer_pkg::VECTOR_NORMAL) else $error("normal vector missing");
    chk_imask_pulse: assert property (imask_clear_o == $rose(wait_i))
        else $error("mask clear pulse wrong");
    chk_core_gate: assert property (core_clk_en_o == (!wait_i && !stop_i))
        else $error("core clock enable wrong");

    ////////////////////////////////////////////////////////////////////////////
    // Register reads; idle read data sits at zero
    chk_bit3_zero: assert property ((read_i && addr_i == timer_pkg::CONTROL_OFFSET)
        |=> !rdata_o[3]) else $error("control bit 3 read as one");
    chk_unmapped_zero: assert property ((read_i && addr_i[1]) |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    ////////////////////////////////////////////////////////////////////////////
    // Stop and external reset presets
    chk_stop_preset: assert property ((stop_i && $past(stop_i) && read_i &&
        addr_i == timer_pkg::COUNTER_OFFSET) |=> rdata_o == timer_pkg::COUNTER_PRESET)
        else $error("counter not preset in stop");
    chk_stop_irq: assert property (stop_i |=> !timer_irq_o)
        else $error("timer irq after stop");
    chk_ext_reset_irq: assert property (ext_reset_i |=> !timer_irq_o)
        else $error("timer irq after external reset");

    // Main scenarios reached
    cov_irq: cover property ($rose(timer_irq_o));
    cov_wait_vec: cover property (vector_o == timer_pkg::VECTOR_WAIT);
    cov_stop_read: cover property (stop_i && read_i);
endmodule

bind prescaled_down_timer prescaled_down_timer_monitor mon_u (
    .clk_i(clk_i), .reset_i(reset_i), .ext_reset_i(ext_reset_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
    .cycle_clk_i(cycle_clk_i), .timer_pin_i(timer_pin_i), .cpu_imask_i(cpu_imask_i),
    .wait_i(wait_i), .stop_i(stop_i), .ext_irq_pending_i(ext_irq_pending_i),
    .timer_irq_o(timer_irq_o), .vector_o(vector_o), .imask_clear_o(imask_clear_o),
    .core_clk_en_o(core_clk_en_o)
);

// ===== verification/timer_far_side.sv
/*
 * Far side model: instruction-cycle clock and timer pin source.
 * Assumes one clock; the pin either toggles at clk/8 or holds a level.
 */
`timescale 1ns/1ps

module timer_far_side (
    input  wire logic clk_i,
    input  wire logic reset_i,
    input  wire logic pin_run_i,
    input  wire logic pin_hold_i,
    output logic      cycle_clk_o,
    output logic      timer_pin_o
);
    logic [2:0] div_q;

    // Free divider; cycle clock never stops, even in wait
    always_ff @(posedge clk_i)
    begin
        div_q <= reset_i ? 3'h0 : div_q + 3'h1;
    end

    // Cycle clock is clk/4, a running pin is clk/8
    assign cycle_clk_o = div_q[1];
    assign timer_pin_o = pin_run_i ? div_q[2] : pin_hold_i;
endmodule

// ===== verification/prescaled_down_timer_bench.sv
/*
 * Self-checking bench for the prescaled down timer.
 * Assumes the far side model drives the count sources.
 */
`timescale 1ns/1ps

module prescaled_down_timer_bench;
    logic        clk_i, reset_i, ext_reset_i, write_i, read_i, cycle_clk_i, timer_pin_i;
    logic        cpu_imask_i, wait_i, stop_i, ext_irq_pending_i, timer_irq_o;
    logic        imask_clear_o, core_clk_en_o, pin_run, pin_hold;
    logic [1:0]  addr_i;
    logic [7:0]  wdata_i, rdata_o, d;
    logic [15:0] vector_o, e;
    int          num_errors, comparisons, i;
    // Mode in [15:8], pin run [7], pin level [6], decrements in 128 cycles [5:0]
    logic [15:0] tbl [0:13] = '{16'h0020, 16'h0110, 16'h0208, 16'h0304, 16'h0402,
        16'h0501, 16'h0600, 16'h0700, 16'h1000, 16'h1060, 16'h2080, 16'h3090,
        16'h3040, 16'h0020};

    prescaled_down_timer dut_u (.clk_i(clk_i), .reset_i(reset_i), .ext_reset_i(ext_reset_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i),
        .rdata_o(rdata_o), .cycle_clk_i(cycle_clk_i), .timer_pin_i(timer_pin_i),
        .cpu_imask_i(cpu_imask_i), .wait_i(wait_i), .stop_i(stop_i),
        .ext_irq_pending_i(ext_irq_pending_i), .timer_irq_o(timer_irq_o),
        .vector_o(vector_o), .imask_clear_o(imask_clear_o), .core_clk_en_o(core_clk_en_o));
    timer_far_side far_u (.clk_i(clk_i), .reset_i(reset_i), .pin_run_i(pin_run),
        .pin_hold_i(pin_hold), .cycle_clk_o(cycle_clk_i), .timer_pin_o(timer_pin_i));

    ////////////////////////////////////////////////////////////////////////////
    // Compare, bus access and closing tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= v;
        write_i <= 1'b1;
        @(posedge clk_i);
        write_i <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, output logic [7:0] v);
        @(posedge clk_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_i);
        read_i <= 1'b0;
        #1 v = rdata_o;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        rd(a, d);
        check({8'h00, d}, {8'h00, exp});
    endtask
    task automatic end_sim();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Clock at 250 MHz
    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {ext_reset_i, write_i, read_i, cpu_imask_i, wait_i, stop_i} = '0;
        {ext_irq_pending_i, pin_run, pin_hold, addr_i, wdata_i} = '0;
        num_errors = 0;
        comparisons = 0;
        reset_i = 1'b1;
        repeat (6) @(posedge clk_i);
        reset_i <= 1'b0;
        rd_chk(timer_pkg::CONTROL_OFFSET, 8'h40);
        wr(2'h3, 8'hff);
        rd_chk(2'h2, 8'h00);
        rd_chk(timer_pkg::CONTROL_OFFSET, 8'h40);
        wr(timer_pkg::CONTROL_OFFSET, 8'h6f);
        rd_chk(timer_pkg::CONTROL_OFFSET, 8'h67);
        // Every divide ratio and source mode; prescaler cleared on each control write
        for (i = 0; i < 14; i++)
        begin
            e = tbl[i];
            pin_run <= e[7];
            pin_hold <= e[6];
            wr(timer_pkg::CONTROL_OFFSET, e[15:8] | 8'h48);
            wr(timer_pkg::COUNTER_OFFSET, 8'h80);
            repeat (128) @(posedge clk_i);
            rd(timer_pkg::COUNTER_OFFSET, d);
            d = 8'h80 - d;
            e[8] = (d + 8'h01 >= {2'b00, e[5:0]}) && (d <= {2'b00, e[5:0]} + 8'h01);
            check({8'h00, d}, e[8] === 1'b1 ? {8'h00, d} : {10'h000, e[5:0]});
        end
        // Natural count to zero raises the request and the interrupt
        wr(timer_pkg::CONTROL_OFFSET, 8'h08);
        wr(timer_pkg::COUNTER_OFFSET, 8'h03);
        for (i = 0; i < 100 && timer_irq_o !== 1'b1; i++) @(posedge clk_i);
        #1 check({15'h0000, timer_irq_o}, 16'h0001);
        if (timer_irq_o !== 1'b1) end_sim();
        repeat (12) @(posedge clk_i);
        rd(timer_pkg::COUNTER_OFFSET, d);
        check({15'h0000, d[7]}, 16'h0001);
        rd_chk(timer_pkg::CONTROL_OFFSET, 8'h80);
        cpu_imask_i <= 1'b1;
        @(posedge clk_i);
        #1 check({15'h0000, timer_irq_o}, 16'h0000);
        cpu_imask_i <= 1'b0;
        wr(timer_pkg::CONTROL_OFFSET, 8'hc0);
        #1 check({15'h0000, timer_irq_o}, 16'h0000);
        rd_chk(timer_pkg::CONTROL_OFFSET, 8'hc0);
        wr(timer_pkg::CONTROL_OFFSET, 8'h00);
        #1 check({15'h0000, timer_irq_o}, 16'h0000);
        // Wait vector, then an external request takes precedence
        wait_i <= 1'b1;
        #1 check({14'h0000, imask_clear_o, core_clk_en_o}, 16'h0002);
        repeat (2) @(posedge clk_i);
        #1 check(vector_o, timer_pkg::VECTOR_WAIT);
        check({14'h0000, imask_clear_o, core_clk_en_o}, 16'h0000);
        ext_irq_pending_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        #1 check(vector_o, timer_pkg::VECTOR_NORMAL);
        {wait_i, ext_irq_pending_i} <= 2'b00;
        // Stop presets the counter, clears flag, sets mask, keeps the rest
        wr(timer_pkg::CONTROL_OFFSET, 8'hb5);
        stop_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk(timer_pkg::COUNTER_OFFSET, timer_pkg::COUNTER_PRESET);
        rd_chk(timer_pkg::CONTROL_OFFSET, 8'h75);
        stop_i <= 1'b0;
        // External reset touches only flag and mask
        wr(timer_pkg::CONTROL_OFFSET, 8'ha2);
        ext_reset_i <= 1'b1;
        @(posedge clk_i);
        ext_reset_i <= 1'b0;
        rd_chk(timer_pkg::CONTROL_OFFSET, 8'h62);
        end_sim();
    end
endmodule
